// File: common/oc_ctrl_pkg.sv
/*
  Shared constants, types and helpers for the two-channel output compare
  control block: register offsets, field layouts, reset values, modes.
  Assumes a 16-bit register data path and byte addresses on an 8-bit bus.
*/
package oc_ctrl_pkg;

  localparam int DATA_W = 16;
  localparam int ADDR_W = 8;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_EVENT_GEN = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_CH_PAIR_CTRL = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_COMPARE_1 = 8'h34;
  localparam logic [ADDR_W-1:0] OFS_COMPARE_2 = 8'h38;
  localparam logic [ADDR_W-1:0] OFS_CH_STATUS = 8'h40;

  // Reset values
  localparam logic [DATA_W-1:0] RST_CH_PAIR_CTRL = 16'h0000;
  localparam logic [DATA_W-1:0] RST_COMPARE = 16'h0000;

  // Field positions
  localparam int BIT_UPDATE_GENERATE = 0;
  localparam int CH1_LSB = 0;
  localparam int CH2_LSB = 8;
  localparam int CH_CFG_W = 8;
  localparam int ST_CH1_REF = 0;
  localparam int ST_CH2_REF = 1;
  localparam int ST_CH1_CAPTURE = 2;
  localparam int ST_CH2_CAPTURE = 3;

  // Protection level that freezes mode and preload of an output channel
  localparam logic [1:0] LOCK_LEVEL_FULL = 2'h3;

  // Trigger register stages before a fast-mode forced level reaches the reference
  localparam int TRIG_FAST_STAGES = 2;

  typedef enum logic [2:0] {
    MODE_FREEZE = 3'b000,
    MODE_MATCH_HIGH = 3'b001,
    MODE_MATCH_LOW = 3'b010,
    MODE_MATCH_TOGGLE = 3'b011,
    MODE_FORCE_LOW = 3'b100,
    MODE_FORCE_HIGH = 3'b101,
    MODE_PWM_ONE = 3'b110,
    MODE_PWM_TWO = 3'b111
  } compare_mode_e;

  typedef enum logic [1:0] {
    DIR_OUTPUT = 2'b00,
    DIR_INPUT_OWN = 2'b01,
    DIR_INPUT_OTHER = 2'b10,
    DIR_INPUT_TRIGGER = 2'b11
  } direction_e;

  // One channel's byte of the control register, msb first
  typedef struct packed {
    logic ref_clear_enable;
    compare_mode_e compare_mode;
    logic compare_preload_en;
    logic fast_response_en;
    direction_e direction_select;
  } ch_cfg_s;

  // Inputs from the timer core that both channels share
  typedef struct packed {
    logic [DATA_W-1:0] count;
    logic count_down;
    logic update_event;
    logic trigger_edge;
    logic filtered_external_trigger;
  } core_status_s;

  function automatic logic is_pwm(input compare_mode_e mode);
    return (mode == MODE_PWM_ONE) || (mode == MODE_PWM_TWO);
  endfunction

endpackage

// File: logic/oc_reference_channel.sv
/*
  Reference waveform generator for one compare channel.
  Assumes the counter, compare value and trigger pulse are synchronous to clk_in.
*/
`timescale 1ns/1ps
module oc_reference_channel #(
  parameter int COUNT_W = oc_ctrl_pkg::DATA_W
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Configuration and compare value
  input oc_ctrl_pkg::ch_cfg_s cfg_in,
  input wire logic [COUNT_W-1:0] compare_in,
  // Timer core
  input wire logic [COUNT_W-1:0] count_in,
  input wire logic count_down_in,
  input wire logic trig_fast_in,
  input wire logic ext_trigger_in,
  // Reference output
  output logic ref_out
);

  logic match_d;
  logic below_d;
  logic above_d;
  oc_ctrl_pkg::compare_mode_e mode_d;
  logic match;
  logic match_rise;
  logic below;
  logic above;
  logic pwm_level;
  logic match_level;
  logic next_ref;

  assign match = (count_in == compare_in);
  assign match_rise = match && !match_d;
  assign below = (count_in < compare_in);
  assign above = (count_in > compare_in);

  // PWM level from the comparison, and the level it takes at the match point
  always_comb begin
    if (cfg_in.compare_mode == oc_ctrl_pkg::MODE_PWM_ONE) begin
      pwm_level = count_down_in ? !above : below;
      match_level = count_down_in;
    end else begin
      pwm_level = count_down_in ? above : !below;
      match_level = !count_down_in;
    end
  end

  always_comb begin
    next_ref = ref_out;
    case (cfg_in.compare_mode)
      oc_ctrl_pkg::MODE_FREEZE: next_ref = ref_out;
      oc_ctrl_pkg::MODE_MATCH_HIGH: next_ref = match_rise ? 1'b1 : ref_out;
      oc_ctrl_pkg::MODE_MATCH_LOW: next_ref = match_rise ? 1'b0 : ref_out;
      oc_ctrl_pkg::MODE_MATCH_TOGGLE: next_ref = match_rise ? !ref_out : ref_out;
      oc_ctrl_pkg::MODE_FORCE_LOW: next_ref = 1'b0;
      oc_ctrl_pkg::MODE_FORCE_HIGH: next_ref = 1'b1;
      oc_ctrl_pkg::MODE_PWM_ONE, oc_ctrl_pkg::MODE_PWM_TWO: begin
        // Level moves only on a new comparison result or on leaving freeze
        if (below != below_d || above != above_d || mode_d == oc_ctrl_pkg::MODE_FREEZE) begin
          next_ref = pwm_level;
        end
        if (cfg_in.fast_response_en && trig_fast_in) begin
          next_ref = match_level;
        end
      end
      default: next_ref = ref_out;
    endcase
    if (cfg_in.ref_clear_enable && ext_trigger_in) begin
      next_ref = 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ref_out <= 1'b0;
    end else begin
      ref_out <= next_ref;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      match_d <= 1'b0;
      below_d <= 1'b0;
      above_d <= 1'b0;
      mode_d <= oc_ctrl_pkg::MODE_FREEZE;
    end else begin
      match_d <= match;
      below_d <= below;
      above_d <= above;
      mode_d <= cfg_in.compare_mode;
    end
  end

endmodule

// File: logic/timer_output_compare_channel_ctrl.sv
/*
  Output compare control for two timer channels: control register,
  compare registers with preload, reference waveforms, capture input
  selection and the software update request.
  Assumes a timer core that supplies the counter, direction, update event,
  trigger edge and filtered external trigger, all synchronous to clk_in.
*/
//
// Behaviour
// - Clear enable zeroes either channel's reference on trigger
// - Reference active high; polarity sets output levels
// - Freeze mode leaves reference unchanged
// - Match sets, clears or toggles reference
// - Modes 100/101 force reference low/high
// - PWM one: high below compare counting up
// - PWM two: low below compare counting up
// - PWM level changes only on comparison change or on leaving freeze
// - Lock level 3 output blocks mode/preload writes
// - Preload on: access preload, copy at update
// - Preload off: writes take effect immediately
// - Fast enable: trigger forces compare level, three cycles
// - Fast off: normal comparison, five cycle minimum
// - Fast enable acts only in PWM modes
// - Direction codes: output, own input, other input
// - Code 11 selects internal trigger when selected
// - Direction writable only while channel disabled
// - Low byte holds channel-1 fields
// - Control register resets to zero
// - Update request reinitialises counter, transfers preload
`timescale 1ns/1ps
module timer_output_compare_channel_ctrl #(
  parameter int COUNT_W = oc_ctrl_pkg::DATA_W
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Register port
  input wire logic [oc_ctrl_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [oc_ctrl_pkg::DATA_W-1:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  output logic [oc_ctrl_pkg::DATA_W-1:0] reg_rdata_out,
  // Timer core status
  input oc_ctrl_pkg::core_status_s core_in,
  input wire logic [COUNT_W-1:0] counter_in,
  // Protection and channel enables
  input wire logic [1:0] lock_level_in,
  input wire logic ch1_channel_enable_in,
  input wire logic ch2_channel_enable_in,
  // Output polarity
  input wire logic ch1_main_polarity_in,
  input wire logic ch1_comp_polarity_in,
  input wire logic ch2_main_polarity_in,
  input wire logic ch2_comp_polarity_in,
  // Capture sources
  input wire logic timer_input_one_in,
  input wire logic timer_input_two_in,
  input wire logic internal_trigger_source_in,
  input wire logic trigger_source_select_internal_in,
  // Reference waveforms
  output logic ch1_reference_wave_out,
  output logic ch2_reference_wave_out,
  // Channel outputs
  output logic ch1_main_output_out,
  output logic ch1_comp_output_out,
  output logic ch2_main_output_out,
  output logic ch2_comp_output_out,
  // Capture inputs
  output logic ch1_capture_input_out,
  output logic ch2_capture_input_out,
  // Update request to the counter core
  output logic update_generate_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Register decode

  localparam int TRIG_STAGES_W = oc_ctrl_pkg::TRIG_FAST_STAGES;

  oc_ctrl_pkg::ch_cfg_s ch1_cfg;
  oc_ctrl_pkg::ch_cfg_s ch2_cfg;
  logic [COUNT_W-1:0] ch1_compare_preload;
  logic [COUNT_W-1:0] ch2_compare_preload;
  logic [COUNT_W-1:0] ch1_compare_active;
  logic [COUNT_W-1:0] ch2_compare_active;
  logic [TRIG_STAGES_W-1:0] trig_pipe;
  logic ch1_ref;
  logic ch2_ref;
  logic preload_transfer;
  logic wr_ctrl;
  logic wr_cmp1;
  logic wr_cmp2;
  logic wr_evgen;
  oc_ctrl_pkg::ch_cfg_s next_ch1_cfg;
  oc_ctrl_pkg::ch_cfg_s next_ch2_cfg;
  logic [oc_ctrl_pkg::DATA_W-1:0] next_rdata;

  assign wr_ctrl = reg_write_in && (reg_addr_in == oc_ctrl_pkg::OFS_CH_PAIR_CTRL);
  assign wr_cmp1 = reg_write_in && (reg_addr_in == oc_ctrl_pkg::OFS_COMPARE_1);
  assign wr_cmp2 = reg_write_in && (reg_addr_in == oc_ctrl_pkg::OFS_COMPARE_2);
  assign wr_evgen = reg_write_in && (reg_addr_in == oc_ctrl_pkg::OFS_EVENT_GEN);

  // A hardware update event or the software request moves preload values
  assign preload_transfer = core_in.update_event || update_generate_out;

  ////////////////////////////////////////////////////////////////////////////
  // Write filter for one channel byte

  function automatic oc_ctrl_pkg::ch_cfg_s filter_cfg(
    input oc_ctrl_pkg::ch_cfg_s cur,
    input oc_ctrl_pkg::ch_cfg_s wr,
    input logic [1:0] lock_level,
    input logic channel_enable
  );
    oc_ctrl_pkg::ch_cfg_s res;
    res = wr;
    if (lock_level == oc_ctrl_pkg::LOCK_LEVEL_FULL &&
        cur.direction_select == oc_ctrl_pkg::DIR_OUTPUT) begin
      res.compare_mode = cur.compare_mode;
      res.compare_preload_en = cur.compare_preload_en;
    end
    if (channel_enable) begin
      res.direction_select = cur.direction_select;
    end
    return res;
  endfunction

  always_comb begin
    next_ch1_cfg = filter_cfg(
      oc_ctrl_pkg::ch_cfg_s'(ch1_cfg),
      reg_wdata_in[oc_ctrl_pkg::CH1_LSB +: oc_ctrl_pkg::CH_CFG_W],
      lock_level_in,
      ch1_channel_enable_in);
    next_ch2_cfg = filter_cfg(
      oc_ctrl_pkg::ch_cfg_s'(ch2_cfg),
      reg_wdata_in[oc_ctrl_pkg::CH2_LSB +: oc_ctrl_pkg::CH_CFG_W],
      lock_level_in,
      ch2_channel_enable_in);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel pair control register

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ch1_cfg <= oc_ctrl_pkg::ch_cfg_s'(
        oc_ctrl_pkg::RST_CH_PAIR_CTRL[oc_ctrl_pkg::CH1_LSB +: oc_ctrl_pkg::CH_CFG_W]);
      ch2_cfg <= oc_ctrl_pkg::ch_cfg_s'(
        oc_ctrl_pkg::RST_CH_PAIR_CTRL[oc_ctrl_pkg::CH2_LSB +: oc_ctrl_pkg::CH_CFG_W]);
    end else if (wr_ctrl) begin
      ch1_cfg <= next_ch1_cfg;
      ch2_cfg <= next_ch2_cfg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare registers with preload

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ch1_compare_preload <= COUNT_W'(oc_ctrl_pkg::RST_COMPARE);
      ch2_compare_preload <= COUNT_W'(oc_ctrl_pkg::RST_COMPARE);
    end else begin
      if (wr_cmp1) begin
        ch1_compare_preload <= COUNT_W'(reg_wdata_in);
      end
      if (wr_cmp2) begin
        ch2_compare_preload <= COUNT_W'(reg_wdata_in);
      end
    end
  end

  // Active copy: direct when preload is off, else loaded on update
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ch1_compare_active <= COUNT_W'(oc_ctrl_pkg::RST_COMPARE);
      ch2_compare_active <= COUNT_W'(oc_ctrl_pkg::RST_COMPARE);
    end else begin
      if (!ch1_cfg.compare_preload_en) begin
        if (wr_cmp1) begin
          ch1_compare_active <= COUNT_W'(reg_wdata_in);
        end
      end else if (preload_transfer) begin
        ch1_compare_active <= ch1_compare_preload;
      end
      if (!ch2_cfg.compare_preload_en) begin
        if (wr_cmp2) begin
          ch2_compare_active <= COUNT_W'(reg_wdata_in);
        end
      end else if (preload_transfer) begin
        ch2_compare_active <= ch2_compare_preload;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software update request

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      update_generate_out <= 1'b0;
    end else begin
      update_generate_out <= wr_evgen && reg_wdata_in[oc_ctrl_pkg::BIT_UPDATE_GENERATE];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Trigger edge pipeline for fast response

  // Two stages plus the reference flop give three cycles from edge to level
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      trig_pipe <= '0;
    end else begin
      trig_pipe <= {trig_pipe[TRIG_STAGES_W-2:0], core_in.trigger_edge};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reference waveforms

  oc_reference_channel #(
    .COUNT_W(COUNT_W)
  ) u_ch1_ref (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .cfg_in(ch1_cfg),
    .compare_in(ch1_compare_active),
    .count_in(counter_in),
    .count_down_in(core_in.count_down),
    .trig_fast_in(trig_pipe[TRIG_STAGES_W-1]),
    .ext_trigger_in(core_in.filtered_external_trigger),
    .ref_out(ch1_ref)
  );

  // Without fast enable only the comparison drives the level
  oc_reference_channel #(
    .COUNT_W(COUNT_W)
  ) u_ch2_ref (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .cfg_in(ch2_cfg),
    .compare_in(ch2_compare_active),
    .count_in(counter_in),
    .count_down_in(core_in.count_down),
    .trig_fast_in(trig_pipe[TRIG_STAGES_W-1]),
    .ext_trigger_in(core_in.filtered_external_trigger),
    .ref_out(ch2_ref)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Output stage

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ch1_reference_wave_out <= 1'b0;
      ch2_reference_wave_out <= 1'b0;
      ch1_main_output_out <= 1'b0;
      ch1_comp_output_out <= 1'b0;
      ch2_main_output_out <= 1'b0;
      ch2_comp_output_out <= 1'b0;
    end else begin
      ch1_reference_wave_out <= ch1_ref;
      ch2_reference_wave_out <= ch2_ref;
      ch1_main_output_out <= ch1_ref ^ ch1_main_polarity_in;
      ch1_comp_output_out <= !ch1_ref ^ ch1_comp_polarity_in;
      ch2_main_output_out <= ch2_ref ^ ch2_main_polarity_in;
      ch2_comp_output_out <= !ch2_ref ^ ch2_comp_polarity_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Capture input selection

  function automatic logic pick_capture(
    input oc_ctrl_pkg::direction_e dir,
    input logic own_input,
    input logic other_input,
    input logic trigger_source,
    input logic trigger_internal
  );
    logic res;
    res = 1'b0;
    case (dir)
      oc_ctrl_pkg::DIR_OUTPUT: res = 1'b0;
      oc_ctrl_pkg::DIR_INPUT_OWN: res = own_input;
      oc_ctrl_pkg::DIR_INPUT_OTHER: res = other_input;
      oc_ctrl_pkg::DIR_INPUT_TRIGGER: res = trigger_internal && trigger_source;
      default: res = 1'b0;
    endcase
    return res;
  endfunction

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ch1_capture_input_out <= 1'b0;
      ch2_capture_input_out <= 1'b0;
    end else begin
      ch1_capture_input_out <= pick_capture(ch1_cfg.direction_select,
        timer_input_one_in, timer_input_two_in,
        internal_trigger_source_in, trigger_source_select_internal_in);
      ch2_capture_input_out <= pick_capture(ch2_cfg.direction_select,
        timer_input_two_in, timer_input_one_in,
        internal_trigger_source_in, trigger_source_select_internal_in);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  always_comb begin
    next_rdata = '0;
    case (reg_addr_in)
      oc_ctrl_pkg::OFS_CH_PAIR_CTRL: next_rdata = {ch2_cfg, ch1_cfg};
      oc_ctrl_pkg::OFS_COMPARE_1: next_rdata = oc_ctrl_pkg::DATA_W'(ch1_compare_preload);
      oc_ctrl_pkg::OFS_COMPARE_2: next_rdata = oc_ctrl_pkg::DATA_W'(ch2_compare_preload);
      oc_ctrl_pkg::OFS_CH_STATUS: begin
        next_rdata[oc_ctrl_pkg::ST_CH1_REF] = ch1_ref;
        next_rdata[oc_ctrl_pkg::ST_CH2_REF] = ch2_ref;
        next_rdata[oc_ctrl_pkg::ST_CH1_CAPTURE] = ch1_capture_input_out;
        next_rdata[oc_ctrl_pkg::ST_CH2_CAPTURE] = ch2_capture_input_out;
      end
      default: next_rdata = '0;
    endcase
  end

  // Data stand only in the cycle after the read strobe
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      reg_rdata_out <= '0;
    end else if (reg_read_in) begin
      reg_rdata_out <= next_rdata;
    end else begin
      reg_rdata_out <= '0;
    end
  end

endmodule

// File: bench/timer_output_compare_channel_ctrl_asserts.sv
/*
  Concurrent checks on the output compare block's top-level ports.
  Assumes one clock domain and a synchronous active high reset.
*/
`timescale 1ns/1ps
module oc_ctrl_checker (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Register port
  input wire logic [oc_ctrl_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [oc_ctrl_pkg::DATA_W-1:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  input wire logic [oc_ctrl_pkg::DATA_W-1:0] reg_rdata_out,
  // Core, protection and polarity
  input oc_ctrl_pkg::core_status_s core_in,
  input wire logic [1:0] lock_level_in,
  input wire logic ch2_channel_enable_in,
  input wire logic ch2_main_polarity_in,
  input wire logic ch2_comp_polarity_in,
  // Observed outputs
  input wire logic ch2_reference_wave_out,
  input wire logic ch2_main_output_out,
  input wire logic ch2_comp_output_out,
  input wire logic update_generate_out
);
  logic [2:0] mode2;
  logic [1:0] dir2;
  logic clr2;
  logic ctrl_wr;
  logic upd_wr;
  logic clear_now;
  assign ctrl_wr = reg_write_in && reg_addr_in == oc_ctrl_pkg::OFS_CH_PAIR_CTRL;
  assign upd_wr = reg_write_in && reg_addr_in == oc_ctrl_pkg::OFS_EVENT_GEN && reg_wdata_in[0];
  assign clear_now = clr2 && core_in.filtered_external_trigger;
  // Shadow of the channel-2 fields, honouring the write interlocks
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mode2 <= 3'h0;
      dir2 <= 2'h0;
      clr2 <= 1'h0;
    end else if (ctrl_wr) begin
      clr2 <= reg_wdata_in[15];
      if (!(lock_level_in == oc_ctrl_pkg::LOCK_LEVEL_FULL && dir2 == 2'h0)) begin
        mode2 <= reg_wdata_in[14:12];
      end
      if (!ch2_channel_enable_in) begin
        dir2 <= reg_wdata_in[9:8];
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  sequence clear_held_s;
    clear_now [*3];
  endsequence
  sequence freeze_held_s;
    (mode2 == 3'h0 && !clear_now) [*4];
  endsequence
  a_update_follows: assert property (upd_wr |=> update_generate_out)
    else $error("update request pulse missing");
  a_update_cause: assert property (update_generate_out |-> $past(upd_wr))
    else $error("update request pulse without write");
  a_rdata_idle: assert property (!$past(reg_read_in) |-> reg_rdata_out == 16'h0000)
    else $error("read data outside read slot");
  a_main_polarity: assert property (!$past(rst_in) |->
    ch2_main_output_out == (ch2_reference_wave_out ^ $past(ch2_main_polarity_in)))
    else $error("main output level wrong");
  a_comp_polarity: assert property (!$past(rst_in) |->
    ch2_comp_output_out == (!ch2_reference_wave_out ^ $past(ch2_comp_polarity_in)))
    else $error("complementary output level wrong");
  a_clear_forces_low: assert property (clear_held_s |=> !ch2_reference_wave_out)
    else $error("reference not cleared");
  a_freeze_holds: assert property (freeze_held_s |-> $stable(ch2_reference_wave_out))
    else $error("reference moved in freeze");
  a_force_high: assert property ((mode2 == 3'h5 && !clear_now) [*3] |=> ch2_reference_wave_out)
    else $error("forced high not held");
  a_force_low: assert property ((mode2 == 3'h4) [*3] |=> !ch2_reference_wave_out)
    else $error("forced low not held");
endmodule

// File: bench/timer_core_model.sv
/*
  Behavioural timer core: counter, direction, update event, trigger.
  Assumes the bench loads the counter; it holds between loads unless an update request clears it.
*/
`timescale 1ns/1ps
module timer_core_model (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Bench control
  input wire logic load_in,
  input wire logic [15:0] load_val_in,
  input wire logic down_in,
  input wire logic trig_in,
  input wire logic ext_in,
  input wire logic upd_req_in,
  // Core status
  output oc_ctrl_pkg::core_status_s core_out,
  output logic [15:0] count_out
);
  // Update request reinitialises the counter
  always_ff @(posedge clk_in) begin
    if (rst_in || upd_req_in) begin
      count_out <= 16'h0000;
    end else if (load_in) begin
      count_out <= load_val_in;
    end
  end
  assign core_out = '{count: count_out, count_down: down_in, update_event: upd_req_in,
    trigger_edge: trig_in, filtered_external_trigger: ext_in};
endmodule

// File: bench/timer_output_compare_channel_ctrl_tb.sv
/*
  Self-checking bench for the two-channel output compare control block.
  Assumes the core model and the checker from this folder.
*/
`timescale 1ns/1ps
module timer_output_compare_channel_ctrl_tb;
  localparam logic [7:0] CTL = oc_ctrl_pkg::OFS_CH_PAIR_CTRL;
  localparam logic [7:0] CMP1 = oc_ctrl_pkg::OFS_COMPARE_1;
  localparam logic [7:0] CMP2 = oc_ctrl_pkg::OFS_COMPARE_2;
  logic clk_in = 1'h0, rst_in = 1'h1, reg_write_in = 1'h0, reg_read_in = 1'h0;
  logic [7:0] reg_addr_in = 8'h00;
  logic [15:0] reg_wdata_in = 16'h0000, load_val = 16'h0000;
  logic [1:0] lock_level_in = 2'h0;
  logic ch1_channel_enable_in = 1'h0, ch2_channel_enable_in = 1'h0;
  logic ch1_main_polarity_in = 1'h0, ch1_comp_polarity_in = 1'h0;
  logic ch2_main_polarity_in = 1'h0, ch2_comp_polarity_in = 1'h0;
  logic timer_input_one_in = 1'h0, timer_input_two_in = 1'h0;
  logic internal_trigger_source_in = 1'h0, trigger_source_select_internal_in = 1'h0;
  logic load = 1'h0, down = 1'h0, trig = 1'h0, ext = 1'h0;
  logic [15:0] reg_rdata_out, counter_in;
  oc_ctrl_pkg::core_status_s core_in;
  logic ch1_reference_wave_out, ch2_reference_wave_out, update_generate_out;
  logic ch1_main_output_out, ch1_comp_output_out, ch2_main_output_out, ch2_comp_output_out;
  logic ch1_capture_input_out, ch2_capture_input_out;
  logic [2:0] mm [8] = '{3'h5, 3'h2, 3'h1, 3'h3, 3'h3, 3'h0, 3'h4, 3'h0};
  logic [3:0] src [3] = '{4'hA, 4'h5, 4'h3};
  int bad_count = 0, num_checks = 0, cycles = 0;
  timer_output_compare_channel_ctrl dut_u (.*);
  timer_core_model core_u (.clk_in(clk_in), .rst_in(rst_in), .load_in(load),
    .load_val_in(load_val), .down_in(down), .trig_in(trig), .ext_in(ext),
    .upd_req_in(update_generate_out), .core_out(core_in), .count_out(counter_in));
  initial begin
    forever #12.5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      test_done();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      bad_count++;
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_write_in <= 1'h1;
    @(posedge clk_in);
    reg_write_in <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_read_in <= 1'h1;
    @(posedge clk_in);
    reg_read_in <= 1'h0;
    #1;
    chk("read data", exp, reg_rdata_out);
  endtask
  task automatic m2(input logic [2:0] m);
    wr(CTL, {1'h0, m, 12'h000});
  endtask
  task automatic cnt(input logic [15:0] v);
    @(posedge clk_in);
    load <= 1'h1;
    load_val <= v;
    @(posedge clk_in);
    load <= 1'h0;
  endtask
  task automatic r2(input logic e);
    cyc(4);
    chk("ch2 reference", {15'h0000, e}, {15'h0000, ch2_reference_wave_out});
  endtask
  task automatic pulse();
    @(posedge clk_in);
    trig <= 1'h1;
    @(posedge clk_in);
    trig <= 1'h0;
  endtask
  function automatic logic pick(input int d, input logic own, input logic other);
    return d == 1 ? own : d == 2 ? other :
      internal_trigger_source_in & trigger_source_select_internal_in;
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk_in);
    rst_in <= 1'h0;
    rd(CTL, 16'h0000);
    rd(8'h20, 16'h0000);
    wr(CTL, 16'hFDFD);
    rd(CTL, 16'hFDFD);
    ch1_channel_enable_in <= 1'h1;
    ch2_channel_enable_in <= 1'h1;
    wr(CTL, 16'h0000);
    rd(CTL, 16'h0101);
    ch1_channel_enable_in <= 1'h0;
    ch2_channel_enable_in <= 1'h0;
    wr(CTL, 16'h0000);
    lock_level_in <= 2'h3;
    wr(CTL, 16'hFCFC);
    rd(CTL, 16'h8484);
    lock_level_in <= 2'h0;
    $display("test registers done");
    for (int p = 0; p < 3; p++) begin
      {timer_input_one_in, timer_input_two_in, internal_trigger_source_in,
        trigger_source_select_internal_in} <= src[p];
      for (int d = 1; d < 4; d++) begin
        wr(CTL, {6'h00, d[1:0], 6'h00, d[1:0]});
        cyc(3);
        chk("ch2 capture", {15'h0000, pick(d, timer_input_two_in, timer_input_one_in)},
          {15'h0000, ch2_capture_input_out});
        chk("ch1 capture", {15'h0000, pick(d, timer_input_one_in, timer_input_two_in)},
          {15'h0000, ch1_capture_input_out});
      end
    end
    $display("test capture select done");
    wr(CMP2, 16'h0005);
    for (int i = 0; i < 8; i++) begin
      m2(mm[i]);
      cnt(16'h0004);
      cnt(16'h0005);
      r2(1'(8'h35 >> i));
    end
    {ch1_main_polarity_in, ch1_comp_polarity_in} <= 2'h3;
    {ch2_main_polarity_in, ch2_comp_polarity_in} <= 2'h3;
    cyc(3);
    chk("ch2 outputs", 16'h0002, {14'h0000, ch2_main_output_out, ch2_comp_output_out});
    // Channel 1 reference was left high by the PWM two setting of the register test
    chk("ch1 outputs", 16'h0001, {14'h0000, ch1_main_output_out, ch1_comp_output_out});
    wr(CTL, 16'hD000);
    ext <= 1'h1;
    r2(1'h0);
    ext <= 1'h0;
    r2(1'h1);
    wr(CTL, 16'h5000);
    ext <= 1'h1;
    r2(1'h1);
    ext <= 1'h0;
    wr(CMP1, 16'h0007);
    wr(CTL, 16'h0020);
    cnt(16'h0006);
    cnt(16'h0007);
    cyc(4);
    chk("ch1 reference", 16'h0000, {15'h0000, ch1_reference_wave_out});
    $display("test match modes done");
    for (int i = 0; i < 8; i++) begin
      if (i % 4 == 0) begin
        m2(3'h0);
      end
      down <= 1'(8'h3C >> i);
      m2(i < 4 ? 3'h6 : 3'h7);
      cnt((8'h96 >> i) & 8'h01 ? 16'h0007 : 16'h0003);
      r2(1'(8'h99 >> i));
    end
    m2(3'h5);
    cnt(16'h0007);
    r2(1'h1);
    m2(3'h6);
    r2(1'h1);
    cnt(16'h0003);
    cnt(16'h0007);
    r2(1'h0);
    $display("test pwm done");
    m2(3'h0);
    wr(CMP2, 16'h0005);
    cnt(16'h0003);
    wr(CTL, 16'h6800);
    r2(1'h1);
    wr(CMP2, 16'h0002);
    r2(1'h1);
    rd(CMP2, 16'h0002);
    wr(oc_ctrl_pkg::OFS_EVENT_GEN, 16'h0001);
    cnt(16'h0003);
    r2(1'h0);
    wr(CTL, 16'h6000);
    wr(CMP2, 16'h0009);
    r2(1'h1);
    $display("test preload done");
    m2(3'h0);
    wr(CMP2, 16'h0005);
    cnt(16'h0003);
    wr(CTL, 16'h6400);
    r2(1'h1);
    pulse();
    r2(1'h0);
    m2(3'h0);
    wr(CTL, 16'h6000);
    r2(1'h1);
    pulse();
    r2(1'h1);
    wr(CTL, 16'h1400);
    down <= 1'h1;
    pulse();
    r2(1'h1);
    $display("test fast response done");
    test_done();
  end
endmodule

bind timer_output_compare_channel_ctrl oc_ctrl_checker chk_u (.*);
